// ### rtl/asdc_device.sv
`timescale 1ns/100ps
// Summary of operation
// - three-bit settle delay, zero to one millisecond
// - delay lengthens conversion unless absorbed
// - absorb delay under half conversion, sinc5
// - absorb only below 10k, four rates excluded
// - 24-bit results, optional rounding to 16
// - pin shows ready, data during reads
// - hold bit keeps data until select rises
// - sync enable resets filter, keeps setup
// - host holds sync low one master period
// - sync low holds filter in reset
// - release on next master edge after rise
// - host raises sync on master rising edge
// - sync rise starts conversion, ready marks end
// - alternate sync: finish, advance, wait high
// - host uses alternate sync with channels
// - conversion error follows range condition
// - bad write checksum flags, status read clears
// - register monitor flags changes, cleared off
// - error pin open-drain OR of flags
// - error pin input joins conversion error
// - error pin off or general output
// - status appended after conversion data
// - write checksum polynomial x^8+x^2+x+1
module asdc_device #(
	parameter int CYC_PER_US = asdc_pkg::CLK_MHZ,
	parameter int CONV_CYC   = asdc_pkg::CONV_US * asdc_pkg::CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	asdc_link_if.dev         link,
	input  wire logic [23:0] sample_in,
	input  wire logic        over_in,
	input  wire logic        under_in,
	input  wire logic        filter_sinc5_in,
	input  wire logic [24:0] odr_csps_in,
	input  wire logic [1:0]  last_chan_in,
	output logic      [23:0] result_out,
	output logic             result_valid,
	output logic      [1:0]  result_chan,
	output logic             sampling
);
	import asdc_pkg::*;

	typedef enum logic [1:0] {CV_HOLD, CV_RUN, CV_WAIT} asdc_cv_t;
	typedef enum logic [2:0] {SP_CMD, SP_WDATA, SP_WCRC, SP_READ, SP_DONE} asdc_sp_t;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_s1_reg;
	logic [4:0] pin_s2_reg;
	logic       sclk_prev_reg;

	// two flops on every pin before any logic reads it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg    <= 5'h1f;
			pin_s2_reg    <= 5'h1f;
			sclk_prev_reg <= 1'b1;
		end
		else
		begin
			pin_s1_reg    <= {link.cs_n, link.sclk, link.din, link.sync_n, link.err_line};
			pin_s2_reg    <= pin_s1_reg;
			sclk_prev_reg <= pin_s2_reg[3];
		end
	end

	wire cs_s   = pin_s2_reg[4];
	wire sclk_s = pin_s2_reg[3];
	wire din_s  = pin_s2_reg[2];
	wire sync_s = pin_s2_reg[1];
	wire err_s  = pin_s2_reg[0];
	wire rise   = !cs_s && sclk_s && !sclk_prev_reg;
	wire fall   = !cs_s && !sclk_s && sclk_prev_reg;

	// ----------------------------------------------------------------
	// registers and field decode
	// ----------------------------------------------------------------
	logic [15:0] mode_reg;
	logic [15:0] ifm_reg;
	logic [15:0] pin_reg;
	logic        rdy_n_reg;
	logic        adc_err_reg;
	logic        crc_err_reg;
	logic        reg_err_reg;
	logic [31:0] snap_reg;
	logic [1:0]  chan_reg;

	wire [2:0] dly_sel               = mode_reg[MODE_DLY_LSB +: 3];
	wire       delay_absorb          = mode_reg[MODE_ABSORB_BIT];
	wire       alternate_sync_select = ifm_reg[IFM_ALTERNATE_SYNC_SELECT];
	wire       dout_hold             = ifm_reg[IFM_DOUT_HOLD];
	wire       status_append         = ifm_reg[IFM_APPEND];
	wire       reg_check             = ifm_reg[IFM_REG_CHECK];
	wire       crc_en                = |ifm_reg[IFM_CRC_LSB +: 2];
	wire       short_word_select     = ifm_reg[IFM_SHORT_WORD];
	wire       sync_en               = pin_reg[PIN_SYNC_EN];
	wire [1:0] err_mode              = pin_reg[PIN_ERR_LSB +: 2];
	wire [7:0] status8 = {rdy_n_reg, adc_err_reg, crc_err_reg, reg_err_reg, 2'b00, chan_reg};
	wire       any_err = adc_err_reg | crc_err_reg | reg_err_reg;

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	asdc_cv_t    cv_state;
	logic [19:0] cv_cnt;
	logic [1:0]  cur_chan_reg;

	wire [19:0] dly_cyc = 20'(DELAY_US[dly_sel] * CYC_PER_US);
	wire odr_ok = (odr_csps_in < ODR_ABSORB_LIMIT) && (odr_csps_in != ODR_NO_ABS_A) &&
		(odr_csps_in != ODR_NO_ABS_B) && (odr_csps_in != ODR_NO_ABS_C) &&
		(odr_csps_in != ODR_NO_ABS_D);
	// absorbing trades filter averages for the settle time
	wire absorb = delay_absorb && filter_sinc5_in && odr_ok &&
		(dly_cyc < 20'(CONV_CYC / 2));
	wire [19:0] conv_total = absorb ? 20'(CONV_CYC) : 20'(CONV_CYC) + dly_cyc;
	wire sync_hold = sync_en && !alternate_sync_select && !sync_s;
	wire alt_stop  = sync_en && alternate_sync_select && !sync_s;
	wire conv_done = (cv_state == CV_RUN) && !sync_hold && (cv_cnt >= conv_total - 20'd1);

	// filter state; sync low holds it cleared, setup registers untouched
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cv_state <= CV_RUN;
			cv_cnt   <= 20'h00000;
		end
		else if (sync_hold)
		begin
			cv_state <= CV_HOLD;
			cv_cnt   <= 20'h00000;
		end
		else
		begin
			case (cv_state)
				CV_HOLD: cv_state <= CV_RUN;
				CV_RUN:
				begin
					cv_cnt <= conv_done ? 20'h00000 : cv_cnt + 20'd1;
					if (conv_done && alt_stop)
						cv_state <= CV_WAIT;
				end
				CV_WAIT:
				begin
					if (!alt_stop)
						cv_state <= CV_RUN;
				end
				default: cv_state <= CV_RUN;
			endcase
		end
	end

	// result path: rounding saturates so 0x..ff80 cannot wrap to zero
	wire [16:0] rnd      = {1'b0, sample_in[23:8]} + 17'(sample_in[7]);
	wire [15:0] r16      = rnd[16] ? 16'hffff : rnd[15:0];
	wire [23:0] conv_val = over_in ? 24'hffffff : under_in ? 24'h000000 :
		short_word_select ? {r16, 8'h00} : sample_in;
	wire adc_cond = over_in | under_in | ((err_mode == ERR_IN) & !err_s);

	// store result, mark ready, step to the next channel
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_out   <= 24'h000000;
			result_valid <= 1'b0;
			result_chan  <= 2'h0;
			chan_reg     <= 2'h0;
			cur_chan_reg <= 2'h0;
			sampling     <= 1'b0;
			adc_err_reg  <= 1'b0;
		end
		else
		begin
			result_valid <= conv_done;
			sampling     <= (cv_state == CV_RUN) && !sync_hold && (cv_cnt >= dly_cyc);
			adc_err_reg  <= adc_cond;
			if (conv_done)
			begin
				result_out   <= conv_val;
				result_chan  <= cur_chan_reg;
				chan_reg     <= cur_chan_reg;
				cur_chan_reg <= (cur_chan_reg == last_chan_in) ? 2'h0 : cur_chan_reg + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	asdc_sp_t    sp_state;
	logic [5:0]  bit_cnt;
	logic [5:0]  len_reg;
	logic [7:0]  cmd_reg;
	logic [23:0] wsh_reg;
	logic [31:0] rsh_reg;
	logic [7:0]  crc_reg;
	logic        dbit_reg;
	logic        dmode_reg;
	logic [3:0]  hold_cnt;

	wire [7:0]  cmd_full = {cmd_reg[6:0], din_s};
	wire [5:0]  cmd_addr = cmd_full[5:0];
	wire        last     = (bit_cnt == len_reg - 6'd1);
	wire [23:0] wsh_next = {wsh_reg[22:0], din_s};
	wire [7:0]  crc_next = {crc_reg[6:0], 1'b0} ^ ((crc_reg[7] ^ din_s) ? CRC_POLY : 8'h00);
	wire [5:0]  cmd_len  = asdc_reg_bits(cmd_addr, short_word_select, status_append);
	wire cmd_end  = rise && (sp_state == SP_CMD) && (bit_cnt == 6'd7);
	wire cmd_ok   = !cmd_full[COMMS_WEN_BIT];
	wire rd_start = cmd_end && cmd_ok && cmd_full[COMMS_READ_BIT];
	wire rd_end   = rise && (sp_state == SP_READ) && last;
	// remainder over message plus received checksum is zero on a match
	wire crc_last = rise && (sp_state == SP_WCRC) && (bit_cnt == 6'd7);
	wire wr_fire  = (rise && (sp_state == SP_WDATA) && last && !crc_en) ||
		(crc_last && (crc_next == 8'h00));
	wire crc_bad  = crc_last && (crc_next != 8'h00);
	wire [15:0] wval = (sp_state == SP_WCRC) ? wsh_reg[15:0] : wsh_next[15:0];
	wire [5:0]  wr_addr = cmd_reg[5:0];
	wire [15:0] pin_rd = (err_mode == ERR_IN) ?
		{pin_reg[15:9], err_s, pin_reg[7:0]} : pin_reg;
	wire [23:0] regsum = {mode_reg, asdc_crc8({pin_reg, 16'h0000}, 6'd16)};

	// read value, left aligned; status trails the data word
	logic [31:0] rd_val;
	always_comb
	begin
		case (cmd_addr)
			ADDR_STATUS: rd_val = {status8, 24'h000000};
			ADDR_MODE:   rd_val = {mode_reg, 16'h0000};
			ADDR_IFM:    rd_val = {ifm_reg, 16'h0000};
			ADDR_REGSUM: rd_val = {regsum, 8'h00};
			ADDR_PIN:    rd_val = {pin_rd, 16'h0000};
			ADDR_DATA:   rd_val = short_word_select ? {result_out[23:8], status8, 8'h00} :
				{result_out, status8};
			default:     rd_val = 32'h00000000;
		endcase
	end

	// frame sequencer: sample on rising, present on falling edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp_state <= SP_CMD;
			bit_cnt  <= 6'd0;
			len_reg  <= 6'd0;
			cmd_reg  <= 8'h00;
			wsh_reg  <= 24'h000000;
			rsh_reg  <= 32'h00000000;
			crc_reg  <= 8'h00;
			dbit_reg <= 1'b1;
		end
		else if (cs_s)
		begin
			sp_state <= SP_CMD;
			bit_cnt  <= 6'd0;
			crc_reg  <= 8'h00;
		end
		else if (rise)
		begin
			bit_cnt <= bit_cnt + 6'd1;
			crc_reg <= crc_next;
			case (sp_state)
				SP_CMD:
				begin
					cmd_reg <= cmd_full;
					if (bit_cnt == 6'd7)
					begin
						bit_cnt  <= 6'd0;
						len_reg  <= cmd_len;
						rsh_reg  <= rd_val;
						sp_state <= !cmd_ok ? SP_DONE :
							cmd_full[COMMS_READ_BIT] ? SP_READ : SP_WDATA;
					end
				end
				SP_WDATA:
				begin
					wsh_reg <= wsh_next;
					if (last)
					begin
						bit_cnt  <= 6'd0;
						sp_state <= crc_en ? SP_WCRC : SP_DONE;
					end
				end
				SP_WCRC:  if (bit_cnt == 6'd7) sp_state <= SP_DONE;
				SP_READ:  if (last) sp_state <= SP_DONE;
				SP_DONE:  bit_cnt <= bit_cnt;
				default:  sp_state <= SP_DONE;
			endcase
		end
		else if (fall && sp_state == SP_READ)
		begin
			dbit_reg <= rsh_reg[31];
			rsh_reg  <= {rsh_reg[30:0], 1'b0};
		end
	end

	// writable registers; monitored ones must be written with checking off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_reg <= MODE_RESET;
			ifm_reg  <= IFM_RESET;
			pin_reg  <= PIN_RESET;
		end
		else if (wr_fire)
		begin
			if (wr_addr == ADDR_MODE)
				mode_reg <= wval;
			if (wr_addr == ADDR_IFM)
				ifm_reg <= wval;
			if (wr_addr == ADDR_PIN)
				pin_reg <= wval;
		end
	end

	// status flags: a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdy_n_reg   <= 1'b1;
			crc_err_reg <= 1'b0;
			reg_err_reg <= 1'b0;
			snap_reg    <= {MODE_RESET, PIN_RESET};
		end
		else
		begin
			rdy_n_reg   <= conv_done ? 1'b0 :
				(rd_end && cmd_reg[5:0] == ADDR_DATA) ? 1'b1 : rdy_n_reg;
			crc_err_reg <= crc_bad | (crc_err_reg & !(rd_start && cmd_addr == ADDR_STATUS));
			snap_reg    <= reg_check ? snap_reg : {mode_reg, pin_reg};
			reg_err_reg <= reg_check &&
				(reg_err_reg || {mode_reg, pin_reg} != snap_reg);
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// data mode ends after a short hold, or on deselect when the hold bit is set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dmode_reg       <= 1'b0;
			hold_cnt        <= 4'h0;
			link.dout_rdy_n <= 1'b1;
			link.err_o      <= 1'b0;
			link.err_oe     <= 1'b0;
		end
		else
		begin
			if (rd_start)
				dmode_reg <= 1'b1;
			else if (cs_s || (!dout_hold && hold_cnt == 4'h1))
				dmode_reg <= 1'b0;
			hold_cnt <= rd_end ? 4'(DOUT_HOLD_CYC) : (hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0;
			link.dout_rdy_n <= dmode_reg ? dbit_reg : rdy_n_reg;
			link.err_o      <= (err_mode == ERR_GPO) & pin_reg[PIN_ERR_LEVEL];
			link.err_oe     <= ((err_mode == ERR_OUT) & any_err) |
				(err_mode == ERR_GPO);
		end
	end
endmodule : asdc_device

// ### rtl/asdc_host.sv
`timescale 1ns/100ps
module asdc_host (
	input  wire logic        clk,
	input  wire logic        rst_n,
	asdc_link_if.host        link,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [5:0]  cmd_addr,
	input  wire logic [23:0] cmd_wdata,
	input  wire logic        single_chan_in,
	input  wire logic        sync_level_in,
	output logic             cmd_ready,
	output logic             cmd_refused,
	output logic             rsp_valid,
	output logic      [31:0] rsp_data,
	output logic             ready_seen,
	output logic             error_seen
);
	import asdc_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} asdc_hs_t;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] s1_reg;
	logic [1:0] s2_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= 2'h3;
			s2_reg <= 2'h3;
		end
		else
		begin
			s1_reg <= {link.dout_rdy_n, link.err_line};
			s2_reg <= s1_reg;
		end
	end

	wire dout_s = s2_reg[1];
	wire err_s  = s2_reg[0];

	// ----------------------------------------------------------------
	// frame build
	// ----------------------------------------------------------------
	asdc_hs_t    h_state;
	logic [3:0]  div_cnt;
	logic [5:0]  bits_left;
	logic [5:0]  len_reg;
	logic        rd_reg;
	logic [39:0] tx_reg;
	logic [39:0] rx_reg;
	logic        sh_short;
	logic        sh_append;
	logic        sh_crc;
	logic        sh_check;

	wire [5:0]  len     = asdc_reg_bits(cmd_addr, sh_short, sh_append);
	wire [7:0]  cmd     = {1'b0, !cmd_write, cmd_addr};
	wire [31:0] msg     = {cmd, cmd_wdata << (6'd24 - len)};
	wire [7:0]  crc     = asdc_crc8(msg, 6'd8 + len);
	// short words leave zero bits at the tail of msg; the checksum must follow the data directly
	wire [39:0] wr_frame = {msg, 8'h00} | (40'(crc) << (6'd24 - len));
	wire        use_crc = cmd_write && sh_crc;
	wire        ifm_wr  = cmd_write && (cmd_addr == ADDR_IFM);
	// monitored registers may only change with checking off
	wire refuse = cmd_write && ((sh_check && !ifm_wr) ||
		(ifm_wr && cmd_wdata[IFM_ALTERNATE_SYNC_SELECT] && single_chan_in));
	wire take   = cmd_valid && cmd_ready && (h_state == H_IDLE);
	wire tick   = (div_cnt == 4'(SCLK_HALF_CYC - 1));
	wire [31:0] rmask = ~(32'hffffffff << len_reg);

	// shadow of the interface mode word, kept from our own writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sh_short  <= IFM_RESET[IFM_SHORT_WORD];
			sh_append <= IFM_RESET[IFM_APPEND];
			sh_crc    <= |IFM_RESET[IFM_CRC_LSB +: 2];
			sh_check  <= IFM_RESET[IFM_REG_CHECK];
		end
		else if (take && ifm_wr && !refuse)
		begin
			sh_short  <= cmd_wdata[IFM_SHORT_WORD];
			sh_append <= cmd_wdata[IFM_APPEND];
			sh_crc    <= |cmd_wdata[IFM_CRC_LSB +: 2];
			sh_check  <= cmd_wdata[IFM_REG_CHECK];
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer: clock idles high, every frame under select
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			h_state     <= H_IDLE;
			div_cnt     <= 4'h0;
			bits_left   <= 6'd0;
			len_reg     <= 6'd0;
			rd_reg      <= 1'b0;
			tx_reg      <= 40'h0;
			rx_reg      <= 40'h0;
			cmd_ready   <= 1'b1;
			cmd_refused <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_data    <= 32'h00000000;
			link.cs_n   <= 1'b1;
			link.sclk   <= 1'b1;
			link.din    <= 1'b1;
		end
		else
		begin
			cmd_refused <= take && refuse;
			rsp_valid   <= 1'b0;
			div_cnt     <= (h_state == H_IDLE || tick) ? 4'h0 : div_cnt + 4'h1;
			case (h_state)
				H_IDLE:
				begin
					if (take && !refuse)
					begin
						h_state   <= H_LEAD;
						cmd_ready <= 1'b0;
						link.cs_n <= 1'b0;
						len_reg   <= len;
						rd_reg    <= !cmd_write;
						bits_left <= 6'd8 + len + (use_crc ? 6'd8 : 6'd0);
						tx_reg    <= cmd_write ? wr_frame : {cmd, 32'h00000000};
					end
				end
				H_LEAD, H_HIGH:
				begin
					if (tick)
					begin
						link.sclk <= 1'b0;
						link.din  <= tx_reg[39];
						tx_reg    <= {tx_reg[38:0], 1'b0};
						h_state   <= H_LOW;
					end
				end
				H_LOW:
				begin
					if (tick)
					begin
						link.sclk <= 1'b1;
						rx_reg    <= {rx_reg[38:0], dout_s};
						bits_left <= bits_left - 6'd1;
						h_state   <= (bits_left == 6'd1) ? H_TAIL : H_HIGH;
					end
				end
				H_TAIL:
				begin
					if (tick)
					begin
						link.cs_n <= 1'b1;
						link.din  <= 1'b1;
						rsp_valid <= rd_reg;
						rsp_data  <= rx_reg[31:0] & rmask;
						h_state   <= H_GAP;
					end
				end
				H_GAP:
				begin
					if (tick)
					begin
						h_state   <= H_IDLE;
						cmd_ready <= 1'b1;
					end
				end
				default: h_state <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sync pin and observed levels
	// ----------------------------------------------------------------
	logic [3:0] low_cnt;

	// sync changes only on a clock edge and stays low a master period
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.sync_n <= 1'b1;
			low_cnt     <= 4'h0;
			ready_seen  <= 1'b0;
			error_seen  <= 1'b0;
		end
		else
		begin
			ready_seen <= (h_state == H_IDLE) && !dout_s;
			error_seen <= !err_s;
			if (link.sync_n && !sync_level_in)
			begin
				link.sync_n <= 1'b0;
				low_cnt     <= 4'h0;
			end
			else if (!link.sync_n && sync_level_in && low_cnt >= 4'(SYNC_LOW_CYC - 1))
				link.sync_n <= 1'b1;
			else if (!link.sync_n && low_cnt != 4'hf)
				low_cnt <= low_cnt + 4'h1;
		end
	end
endmodule : asdc_host

// ### rtl/asdc_link_if.sv
`timescale 1ns/100ps
interface asdc_link_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout_rdy_n;
	logic sync_n;
	logic err_o;
	logic err_oe;
	wire  err_line;

	// open-drain line with pull-up
	assign err_line = err_oe ? err_o : 1'b1;

	modport dev (input cs_n, input sclk, input din, input sync_n, input err_line,
		output dout_rdy_n, output err_o, output err_oe);
	modport host (output cs_n, output sclk, output din, output sync_n,
		input dout_rdy_n, input err_line);
endinterface : asdc_link_if

// ### rtl/asdc_pkg.sv
package asdc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_STATUS = 6'h00;
	localparam logic [5:0] ADDR_MODE   = 6'h01; // converter_mode_control
	localparam logic [5:0] ADDR_IFM    = 6'h02; // interface_mode_control
	localparam logic [5:0] ADDR_REGSUM = 6'h03; // register_checksum
	localparam logic [5:0] ADDR_DATA   = 6'h04;
	localparam logic [5:0] ADDR_PIN    = 6'h06; // pin_config_register

	localparam logic [15:0] MODE_RESET = 16'ha000;
	localparam logic [15:0] IFM_RESET  = 16'h0000;
	localparam logic [15:0] PIN_RESET  = 16'h0800;

	// field positions
	localparam int COMMS_WEN_BIT   = 7; // must be zero for a valid command
	localparam int COMMS_READ_BIT  = 6;
	localparam int MODE_ABSORB_BIT = 14;
	localparam int MODE_DLY_LSB    = 8;
	localparam int IFM_ALTERNATE_SYNC_SELECT    = 12;
	localparam int IFM_DOUT_HOLD   = 8;
	localparam int IFM_APPEND      = 6;
	localparam int IFM_REG_CHECK   = 5;
	localparam int IFM_CRC_LSB     = 2;
	localparam int IFM_SHORT_WORD  = 0;
	localparam int PIN_SYNC_EN     = 11;
	localparam int PIN_ERR_LSB     = 9;
	localparam int PIN_ERR_LEVEL   = 8;

	// error pin functions
	localparam logic [1:0] ERR_OFF = 2'h0;
	localparam logic [1:0] ERR_IN  = 2'h1;
	localparam logic [1:0] ERR_OUT = 2'h2;
	localparam logic [1:0] ERR_GPO = 2'h3;

	localparam logic [7:0] CRC_POLY = 8'h07; // x^8 + x^2 + x + 1

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int CONV_US       = 100;
	localparam int DELAY_US [8]  = '{0, 25, 50, 100, 200, 400, 700, 1000};
	localparam int DOUT_HOLD_NS  = 20;
	localparam int DOUT_HOLD_CYC = (DOUT_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SCLK_HALF_NS  = 80;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS * CLK_MHZ / 1000;
	localparam int SYNC_LOW_NS   = 10;
	localparam int SYNC_LOW_CYC  = (SYNC_LOW_NS * CLK_MHZ + 999) / 1000;

	// output data rates in hundredths of a sample per second
	localparam logic [24:0] ODR_ABSORB_LIMIT = 25'd1000000;
	localparam logic [24:0] ODR_NO_ABS_A     = 25'd39750;
	localparam logic [24:0] ODR_NO_ABS_B     = 25'd5992;
	localparam logic [24:0] ODR_NO_ABS_C     = 25'd4996;
	localparam logic [24:0] ODR_NO_ABS_D     = 25'd1666;

	// bits moved in the data phase of a frame
	function automatic logic [5:0] asdc_reg_bits(input logic [5:0] addr,
		input logic short_word, input logic append);
		case (addr)
			ADDR_STATUS: return 6'd8;
			ADDR_MODE, ADDR_IFM, ADDR_PIN: return 6'd16;
			ADDR_REGSUM: return 6'd24;
			ADDR_DATA: return (short_word ? 6'd16 : 6'd24) + (append ? 6'd8 : 6'd0);
			default: return 6'd8;
		endcase
	endfunction : asdc_reg_bits

	// write checksum over the first nbits of msg, msb first
	function automatic logic [7:0] asdc_crc8(input logic [31:0] msg, input logic [5:0] nbits);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			if (6'(31 - i) < nbits)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : asdc_crc8
endpackage : asdc_pkg

// ### testbench/asdc_assertions.sv
`timescale 1ns/100ps
module asdc_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// halves under six cycles would outrun the device's two-flop synchronizer
	sequence s_low_half;
		!sclk[*5];
	endsequence
	sequence s_high_half;
		sclk[*5];
	endsequence

	// serial clock shape and framing
	chk_sclk_low_half: assert property ($fell(sclk) |=> s_low_half)
		else $error("sclk low half too short");
	chk_sclk_high_half: assert property ($rose(sclk) |=> s_high_half)
		else $error("sclk high half too short");
	chk_sclk_idle_high: assert property (cs_n |-> sclk)
		else $error("sclk moved outside a frame");
	chk_cs_rise_idle: assert property ($rose(cs_n) |-> sclk && $past(sclk))
		else $error("select released with sclk low");
	chk_cs_fall_setup: assert property ($fell(cs_n) |=> sclk[*6])
		else $error("sclk fell too soon after select");
	chk_frame_min_len: assert property ($fell(cs_n) |=> !cs_n[*8])
		else $error("frame too short");
	chk_frame_ends_bounded: assert property ($fell(cs_n) |-> ##[1:1000] cs_n)
		else $error("frame never closed");
	// the device samples din on the rising edge, so it must be settled there
	chk_din_stable_rise: assert property ($rose(sclk) |-> $stable(din))
		else $error("din changed at sclk rise");
endmodule : asdc_assertions

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
	import asdc_pkg::*;
	localparam int          CONV     = 200;
	localparam logic [15:0] MODES[5] = '{16'ha300, 16'he200, 16'he300, 16'he200, 16'he200};
	localparam logic [24:0] ODRS[5]  = '{25'h3e8, 25'h3e8, 25'h3e8, ODR_NO_ABS_A, ODR_ABSORB_LIMIT};
	localparam int          DLY[5]   = '{100, 0, 100, 50, 50};

	logic        clk           = 1'b0;
	logic        rst_n         = 1'b0;
	logic        cmd_valid     = 1'b0;
	logic        cmd_write     = 1'b0;
	logic [5:0]  cmd_addr      = 6'h00;
	logic [23:0] cmd_wdata     = 24'h000000;
	logic        sync_level_in = 1'b1;
	logic        over_in       = 1'b0;
	logic [24:0] odr_csps_in   = 25'h3e8;
	logic        single_chan_in = 1'b0;
	logic        cmd_ready, rsp_valid, result_valid, sampling, cmd_refused, error_seen;
	int          n_refused     = 0;
	logic [31:0] rsp_data;
	int          num_errors    = 0;
	int          n_tests       = 0;
	int          waited        = 0;
	wire logic [2:0] ev = {result_valid, rsp_valid, cmd_ready};

	// both ends joined across the link, checker beside it
	asdc_link_if link ();
	asdc_device #(.CYC_PER_US(1), .CONV_CYC(CONV)) u_asdc_device (.clk(clk), .rst_n(rst_n),
		.link(link.dev), .sample_in(24'h1234c0), .over_in(over_in), .under_in(1'b0),
		.filter_sinc5_in(1'b1), .odr_csps_in(odr_csps_in), .last_chan_in(2'h0),
		.result_out(), .result_valid(result_valid), .result_chan(), .sampling(sampling));
	asdc_host u_asdc_host (.clk(clk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.single_chan_in(single_chan_in), .sync_level_in(sync_level_in),
		.cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .ready_seen(), .error_seen(error_seen));
	asdc_assertions u_asdc_assertions (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n),
		.sclk(link.sclk), .din(link.din));

	// 100 MHz system clock
	always #5 clk = ~clk;

	// a refused command leaves no trace on the link, so count its pulses
	always @(negedge clk)
		if (cmd_refused === 1'b1)
			n_refused++;

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// case inequality so an unknown never passes for a match
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : chk

	// bounded wait on a design event; running out ends the run
	task automatic wait_ok(input int k, input int lim);
		for (waited = 0; waited < lim && ev[k] !== 1'b1; waited++)
			@(negedge clk);
		if (waited == lim)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wait_ok

	// one command; request held across the taking edge
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d);
		wait_ok(0, 3000);
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		@(negedge clk);
		wait_ok(wr ? 0 : 1, 3000);
	endtask : xfer

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		xfer(1'b0, a, 24'h000000);
		chk(rsp_data, e);
	endtask : rd

	task automatic err_step(input logic ovr);
		over_in = ovr;
		wait_ok(2, 3000);
		xfer(1'b0, ADDR_STATUS, 24'h000000);
		chk(32'(rsp_data[6]), 32'(ovr)); // conversion error follows range
		chk(32'(link.err_line), 32'(!ovr)); // open-drain error output
		chk(32'(error_seen), 32'(ovr)); // host sees the error line
	endtask : err_step

	// main sequence
	initial
	begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		rd(ADDR_MODE, 32'h0000a000); // mode reset
		rd(ADDR_IFM, 32'h00000000); // 24-bit default
		rd(ADDR_PIN, 32'h00000800); // sync enabled
		rd(6'h3f, 32'h00000000); // unmapped reads zero
		wait_ok(2, 3000);
		rd(ADDR_DATA, 32'h001234c0); // full width
		xfer(1'b1, ADDR_IFM, 24'h000001);
		wait_ok(2, 3000); // a conversion must land at the new width first
		rd(ADDR_DATA, 32'h00001235); // rounded result
		xfer(1'b1, ADDR_IFM, 24'h000041);
		xfer(1'b0, ADDR_DATA, 24'h000000);
		chk({8'h00, rsp_data[23:8], 6'h00, rsp_data[1:0]}, 32'h00123500); // status tail
		xfer(1'b1, ADDR_IFM, 24'h000000);
		single_chan_in = 1'b1;
		xfer(1'b1, ADDR_IFM, 24'h001000);
		rd(ADDR_IFM, 32'h00000000); // alternate sync kept off
		chk(n_refused, 32'h1); // exactly one refusal
		single_chan_in = 1'b0;
		sync_level_in = 1'b0;
		repeat (300) @(negedge clk);
		chk(32'(sampling), 32'h0); // held while sync low
		sync_level_in = 1'b1;
		wait_ok(2, 3000);
		chk(32'(waited >= CONV - 5 && waited <= CONV + 10), 32'h1); // restart
		xfer(1'b1, ADDR_PIN, 24'h000c00);
		err_step(1'b1);
		err_step(1'b0);
		for (int l = 0; l < 2; l++)
		begin
			xfer(1'b1, ADDR_PIN, 24'h000e00 | 24'(l << 8));
			chk(32'(link.err_line), 32'(l)); // general output level
		end
		xfer(1'b1, ADDR_PIN, 24'h000800);
		chk(32'(link.err_line), 32'h1); // disabled pin pulled up
		xfer(1'b1, ADDR_IFM, 24'h000004);
		xfer(1'b1, ADDR_MODE, 24'h00a100);
		rd(ADDR_MODE, 32'h0000a100); // checksummed write lands
		xfer(1'b0, ADDR_STATUS, 24'h000000);
		chk(32'(rsp_data[5]), 32'h0); // matching checksum sets no flag
		xfer(1'b1, ADDR_IFM, 24'h000000);
		for (int k = 0; k < 5; k++)
		begin
			odr_csps_in = ODRS[k];
			xfer(1'b1, ADDR_MODE, 24'(MODES[k]));
			rd(ADDR_MODE, 32'(MODES[k])); // delay field
			wait_ok(2, 3000);
			@(negedge clk);
			wait_ok(2, 3000);
			@(negedge clk);
			wait_ok(2, 3000);
			chk(32'(waited + 1), 32'(CONV + DLY[k])); // period
		end
		complete_run();
	end
endmodule : tb
